// ### design/cscc_defs.svh
`ifndef CSCC_DEFS_SVH
`define CSCC_DEFS_SVH
// register indices and byte addresses on the bus
`define CSCC_IDX_STATUS   4'h0
`define CSCC_IDX_CONTROL  4'h1
`define CSCC_IDX_PCWIN    4'h2
`define CSCC_IDX_LOOP     4'h3
`define CSCC_ADR_STATUS   6'h00
`define CSCC_ADR_CONTROL  6'h04
`define CSCC_ADR_PCWIN    6'h08
`define CSCC_ADR_LOOP     6'h0c
// status word bit positions
`define CSCC_SR_C         0
`define CSCC_SR_Z         1
`define CSCC_SR_OV        2
`define CSCC_SR_N         3
`define CSCC_SR_RA        4
`define CSCC_SR_PRI_LO    5
`define CSCC_SR_PRI_HI    7
`define CSCC_SR_DC        8
`define CSCC_SR_DA        9
`define CSCC_SR_SAB       10
`define CSCC_SR_OAB       11
`define CSCC_SR_SB        12
`define CSCC_SR_SA        13
`define CSCC_SR_OB        14
`define CSCC_SR_OA        15
// control word bit positions and reset value
`define CSCC_CC_PSV       2
`define CSCC_CC_PRI3      3
`define CSCC_CC_RST       16'h0020
`define CSCC_CC_WMASK     16'h18f7
// machine figures
`define CSCC_PC_W         23
`define CSCC_INSN_W       24
`define CSCC_DIV_CYCLES   5'h13
`define CSCC_PRI_MAX      3'h7
`define CSCC_GUARD_LO     32
`define CSCC_GUARD_HI     39
`define CSCC_WIN_BASE     16'h8000
`define CSCC_SHIFT_MAX    5'h10
`endif

// ### design/cscc_pkg.sv
package cscc_pkg;
    typedef enum logic [1:0] {
        CSCC_OP_NONE,
        CSCC_OP_BYTE,
        CSCC_OP_WORD
    } cscc_size_t;
    typedef enum {
        CSCC_DIV_IDLE,
        CSCC_DIV_RUN
    } cscc_div_t;
endpackage

// ### design/cscc_core_state.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cscc_defs.svh"
module cscc_core_state
    import cscc_pkg::*;
#(
    parameter int PAGE_W = 8
) (
    input  wire logic                   CLOCK,
    input  wire logic                   RST,
    input  wire logic [5:0]             WB_ADR_I,
    input  wire logic [31:0]            WB_DAT_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic                   WB_WE_I,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    output logic [31:0]                 WB_DAT_O,
    output logic                        WB_ACK_O,
    input  wire logic                   ALU_VALID,
    input  wire logic                   ALU_SUB,
    input  wire logic                   ALU_BYTE,
    input  wire logic [15:0]            ALU_A,
    input  wire logic [15:0]            ALU_B,
    input  wire logic [39:0]            ACC_A,
    input  wire logic [39:0]            ACC_B,
    input  wire logic                   CLAMP_A_EVT,
    input  wire logic                   CLAMP_B_EVT,
    input  wire logic                   BLOCK_LOOP_RUN,
    input  wire logic                   REPEAT_RUN,
    input  wire logic                   NESTING_DISABLE,
    input  wire logic                   DIV_START,
    input  wire logic                   HOLD,
    input  wire logic [15:0]            DATA_ADDR,
    input  wire logic [16:0]            MUL_X,
    input  wire logic [16:0]            MUL_Y,
    input  wire logic [39:0]            SHIFT_IN,
    input  wire logic [4:0]             SHIFT_AMT,
    input  wire logic                   SHIFT_LEFT,
    output logic [15:0]                 ALU_RESULT,
    output logic [33:0]                 MUL_PRODUCT,
    output logic [39:0]                 SHIFT_OUT,
    output logic [`CSCC_PC_W-1:0]       PROG_ADDR,
    output logic                        PROG_WINDOW_HIT,
    output logic [3:0]                  CPU_PRIORITY,
    output logic                        USER_INT_BLOCK,
    output logic                        DIV_BUSY
);
    logic [15:0]       status_ff;
    logic [15:0]       control_ff;
    logic [PAGE_W-1:0] page_ff;
    logic [4:0]        div_cnt_ff;
    cscc_div_t         div_st_ff;
    logic              ack_ff;
    logic [31:0]       rdata_ff;
    logic [15:0]       res_ff;
    logic [33:0]       prod_ff;
    logic [39:0]       shf_ff;
    logic [`CSCC_PC_W-1:0] paddr_ff;
    logic              hit_ff;
    logic [3:0]        pri_ff;
    logic              blk_ff;
    logic              busy_ff;

    function automatic logic guard_spill(input logic [39:0] acc);
        guard_spill = !((&acc[`CSCC_GUARD_HI:`CSCC_GUARD_LO])
                      | ~(|acc[`CSCC_GUARD_HI:`CSCC_GUARD_LO]));
    endfunction

    // bus decode; one wait cycle, ack follows the request by one edge
    wire        bus_req   = WB_CYC_I & WB_STB_I & ~ack_ff;
    wire        wr_lo     = bus_req & WB_WE_I & WB_SEL_I[0];
    wire        wr_hi     = bus_req & WB_WE_I & WB_SEL_I[1];
    wire        sel_sr    = WB_ADR_I == `CSCC_ADR_STATUS;
    wire        sel_cc    = WB_ADR_I == `CSCC_ADR_CONTROL;
    wire        sel_pg    = WB_ADR_I == `CSCC_ADR_PCWIN;
    wire        sel_lp    = WB_ADR_I == `CSCC_ADR_LOOP;
    wire [15:0] wd        = WB_DAT_I[15:0];

    // alu flag generation
    wire [16:0] opb       = ALU_SUB ? {1'b0, ~ALU_B} : {1'b0, ALU_B};
    wire [16:0] sum       = {1'b0, ALU_A} + opb + {16'h0000, ALU_SUB};
    wire [8:0]  lo9       = {1'b0, ALU_A[7:0]} + {1'b0, opb[7:0]} + {8'h00, ALU_SUB};
    wire [4:0]  lo5       = {1'b0, ALU_A[3:0]} + {1'b0, opb[3:0]} + {4'h0, ALU_SUB};
    wire [15:0] res       = sum[15:0];
    wire        msb_a     = ALU_BYTE ? ALU_A[7] : ALU_A[15];
    wire        msb_b     = ALU_BYTE ? opb[7] : opb[15];
    wire        msb_r     = ALU_BYTE ? res[7] : res[15];
    wire        f_c       = ALU_BYTE ? lo9[8] : sum[16];
    wire        f_dc      = ALU_BYTE ? lo5[4] : lo9[8];
    wire        f_n       = msb_r;
    wire        f_ov      = (msb_a == msb_b) & (msb_r != msb_a);
    wire        f_nz      = ALU_BYTE ? |res[7:0] : |res;
    wire        spill_a   = guard_spill(ACC_A);
    wire        spill_b   = guard_spill(ACC_B);

    // reference arithmetic for the checks, kept apart from the flag path
    wire [16:0] ref_add   = {1'b0, ALU_A} + {1'b0, ALU_B};
    wire [15:0] ref_res   = ALU_SUB ? ALU_A - ALU_B : ref_add[15:0];
    wire        ref_cy    = ALU_SUB ? (ALU_A >= ALU_B) : ref_add[16];
    wire [4:0]  ref_nib   = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
    wire        word_op   = ALU_VALID & ~ALU_BYTE;

    a_result_reg: assert property (@(posedge CLOCK) disable iff (RST)
        ALU_VALID |=> ALU_RESULT == $past(ref_res))
        else $error("alu result not taken in one cycle");
    a_word_carry: assert property (@(posedge CLOCK) disable iff (RST)
        word_op |=> status_ff[`CSCC_SR_C] == $past(ref_cy))
        else $error("carry flag wrong");
    a_word_neg: assert property (@(posedge CLOCK) disable iff (RST)
        word_op |=> status_ff[`CSCC_SR_N] == $past(ref_res[15]))
        else $error("negative flag wrong");
    a_word_zero: assert property (@(posedge CLOCK) disable iff (RST)
        word_op |=> status_ff[`CSCC_SR_Z] == ($past(ref_res) == 16'h0000))
        else $error("zero flag wrong");
    a_word_ovf: assert property (@(posedge CLOCK) disable iff (RST)
        word_op & ~ALU_SUB & ~ALU_A[15] & ~ALU_B[15]
            |=> status_ff[`CSCC_SR_OV] == $past(ref_res[15]))
        else $error("overflow flag wrong");
    a_byte_half: assert property (@(posedge CLOCK) disable iff (RST)
        ALU_VALID & ALU_BYTE & ~ALU_SUB |=> status_ff[`CSCC_SR_DC] == $past(ref_nib[4]))
        else $error("half carry wrong");

    // software writes into the status word
    wire        pri_wr    = wr_lo & sel_sr & ~NESTING_DISABLE;
    wire        clr_sab   = wr_hi & sel_sr & ~wd[`CSCC_SR_SAB];
    wire        clr_sa    = (wr_hi & sel_sr & ~wd[`CSCC_SR_SA]) | clr_sab;
    wire        clr_sb    = (wr_hi & sel_sr & ~wd[`CSCC_SR_SB]) | clr_sab;
    // set wins over clear; writing one never sets
    wire        nxt_sa    = CLAMP_A_EVT | (status_ff[`CSCC_SR_SA] & ~clr_sa);
    wire        nxt_sb    = CLAMP_B_EVT | (status_ff[`CSCC_SR_SB] & ~clr_sb);
    wire [2:0]  nxt_pri   = pri_wr ? wd[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO]
                                   : status_ff[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO];
    wire        sw_lo     = wr_lo & sel_sr;
    wire        nxt_c     = ALU_VALID ? f_c  : sw_lo ? wd[`CSCC_SR_C]  : status_ff[`CSCC_SR_C];
    wire        nxt_ov    = ALU_VALID ? f_ov : sw_lo ? wd[`CSCC_SR_OV] : status_ff[`CSCC_SR_OV];
    wire        nxt_n     = ALU_VALID ? f_n  : sw_lo ? wd[`CSCC_SR_N]  : status_ff[`CSCC_SR_N];
    // zero stays set until a non-zero result clears it
    wire        nxt_z     = ALU_VALID ? (status_ff[`CSCC_SR_Z] & ~f_nz) | ~f_nz
                          : sw_lo ? wd[`CSCC_SR_Z] : status_ff[`CSCC_SR_Z];
    wire        nxt_dc    = ALU_VALID ? f_dc : (wr_hi & sel_sr) ? wd[`CSCC_SR_DC]
                                            : status_ff[`CSCC_SR_DC];
    wire [15:0] nxt_status = {spill_a, spill_b, nxt_sa, nxt_sb,
                              spill_a | spill_b, nxt_sa | nxt_sb,
                              BLOCK_LOOP_RUN, nxt_dc, nxt_pri,
                              REPEAT_RUN, nxt_n, nxt_ov, nxt_z, nxt_c};

    // control word: top priority bit is clear-only, others by mask
    wire [15:0] cc_wmask  = {WB_SEL_I[1] ? 8'hff : 8'h00, WB_SEL_I[0] ? 8'hff : 8'h00}
                          & `CSCC_CC_WMASK;
    wire        cc_wr     = bus_req & WB_WE_I & sel_cc;
    wire        pri3_clr  = cc_wr & WB_SEL_I[0] & ~wd[`CSCC_CC_PRI3];
    wire [15:0] cc_merge  = cc_wr ? (control_ff & ~cc_wmask) | (wd & cc_wmask) : control_ff;
    wire [15:0] nxt_control = {cc_merge[15:`CSCC_CC_PRI3+1],
                               control_ff[`CSCC_CC_PRI3] & ~pri3_clr,
                               cc_merge[`CSCC_CC_PRI3-1:0]};
    wire [PAGE_W-1:0] nxt_page = (wr_lo & sel_pg) ? wd[PAGE_W-1:0] : page_ff;

    // four-bit priority and interrupt blocking
    wire [3:0]  nxt_prio  = {nxt_control[`CSCC_CC_PRI3], nxt_pri};
    wire        nxt_blk   = nxt_control[`CSCC_CC_PRI3]
                          | (nxt_pri == `CSCC_PRI_MAX);

    // program window: upper half of data space into program memory
    wire        win_hit   = control_ff[`CSCC_CC_PSV] & DATA_ADDR[15];
    wire [`CSCC_PC_W-1:0] win_addr = {{(`CSCC_PC_W-PAGE_W-15){1'b0}}, page_ff, DATA_ADDR[14:0]};

    // shared multiplier; 17-bit operands make -1 x -1 exact
    wire [33:0] nxt_prod  = {{17{MUL_X[16]}}, MUL_X} * {{17{MUL_Y[16]}}, MUL_Y};
    // single-cycle barrel shift, amount capped at 16
    wire [4:0]  amt       = (SHIFT_AMT > `CSCC_SHIFT_MAX) ? `CSCC_SHIFT_MAX : SHIFT_AMT;
    wire [39:0] nxt_shf   = SHIFT_LEFT ? (SHIFT_IN << amt)
                                       : 40'($signed(SHIFT_IN) >>> amt);

    // divide iteration counter; HOLD (interrupt entry) freezes it, nothing lost
    wire        div_done  = div_cnt_ff == 5'h01;
    wire [4:0]  nxt_div_cnt = (div_st_ff == CSCC_DIV_RUN)
                            ? (HOLD ? div_cnt_ff : div_cnt_ff - 5'h01)
                            : (DIV_START ? `CSCC_DIV_CYCLES : 5'h00);
    cscc_div_t  nxt_div_st;
    always_comb begin
        case (div_st_ff)
            CSCC_DIV_IDLE: nxt_div_st = DIV_START ? CSCC_DIV_RUN : CSCC_DIV_IDLE;
            CSCC_DIV_RUN:  nxt_div_st = (div_done & ~HOLD) ? CSCC_DIV_IDLE : CSCC_DIV_RUN;
            default:       nxt_div_st = CSCC_DIV_IDLE;
        endcase
    end

    wire [15:0] rd_word   = sel_sr ? status_ff
                          : sel_cc ? control_ff
                          : sel_pg ? {{(16-PAGE_W){1'b0}}, page_ff}
                          : sel_lp ? {11'h000, div_cnt_ff}
                          : 16'h0000;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            status_ff  <= 16'h0000;
            control_ff <= `CSCC_CC_RST;
            page_ff    <= '0;
            div_cnt_ff <= 5'h00;
            div_st_ff  <= CSCC_DIV_IDLE;
            ack_ff     <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            busy_ff    <= 1'b0;
        end else begin
            status_ff  <= nxt_status;
            control_ff <= nxt_control;
            page_ff    <= nxt_page;
            div_cnt_ff <= nxt_div_cnt;
            div_st_ff  <= nxt_div_st;
            ack_ff     <= bus_req;
            rdata_ff   <= bus_req ? {16'h0000, rd_word} : 32'h0000_0000;
            busy_ff    <= nxt_div_st == CSCC_DIV_RUN;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            res_ff   <= 16'h0000;
            prod_ff  <= 34'h0;
            shf_ff   <= 40'h0;
            paddr_ff <= '0;
            hit_ff   <= 1'b0;
            pri_ff   <= 4'h0;
            blk_ff   <= 1'b0;
        end else begin
            res_ff   <= ALU_VALID ? res : res_ff;
            prod_ff  <= nxt_prod;
            shf_ff   <= nxt_shf;
            paddr_ff <= win_addr;
            hit_ff   <= win_hit;
            pri_ff   <= nxt_prio;
            blk_ff   <= nxt_blk;
        end
    end

    assign WB_DAT_O        = rdata_ff;
    assign WB_ACK_O        = ack_ff;
    assign ALU_RESULT      = res_ff;
    assign MUL_PRODUCT     = prod_ff;
    assign SHIFT_OUT       = shf_ff;
    assign PROG_ADDR       = paddr_ff;
    assign PROG_WINDOW_HIT = hit_ff;
    assign CPU_PRIORITY    = pri_ff;
    assign USER_INT_BLOCK  = blk_ff;
    assign DIV_BUSY        = busy_ff;

    a_sticky_clamp: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(status_ff[`CSCC_SR_SA]) |-> $past(CLAMP_A_EVT))
        else $error("clamp flag set without event");
    a_combined_clr: assert property (@(posedge CLOCK) disable iff (RST)
        $past(clr_sab) & ~$past(CLAMP_A_EVT) & ~$past(CLAMP_B_EVT)
            |-> ~status_ff[`CSCC_SR_SA] & ~status_ff[`CSCC_SR_SB])
        else $error("combined clear missed a flag");
    a_spill_or: assert property (@(posedge CLOCK) disable iff (RST)
        status_ff[`CSCC_SR_OAB] == (status_ff[`CSCC_SR_OA] | status_ff[`CSCC_SR_OB]))
        else $error("combined spill mismatch");
    a_guard_spill: assert property (@(posedge CLOCK) disable iff (RST)
        ##1 status_ff[`CSCC_SR_OA] == $past(ACC_A[39:32] != 8'h00 && ACC_A[39:32] != 8'hff))
        else $error("guard spill wrong");
    a_loop_flag: assert property (@(posedge CLOCK) disable iff (RST)
        ##1 status_ff[`CSCC_SR_DA] == $past(BLOCK_LOOP_RUN))
        else $error("block loop flag wrong");
    a_pri_locked: assert property (@(posedge CLOCK) disable iff (RST)
        NESTING_DISABLE |=> $stable(status_ff[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO]))
        else $error("priority changed while locked");
    a_pri3_noset: assert property (@(posedge CLOCK) disable iff (RST)
        ~control_ff[`CSCC_CC_PRI3] |=> ~control_ff[`CSCC_CC_PRI3])
        else $error("top priority bit set by write");
    a_int_block: assert property (@(posedge CLOCK) disable iff (RST)
        (status_ff[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO] == 3'h7) |-> USER_INT_BLOCK)
        else $error("user interrupts not blocked");
    sequence s_div_begin;
        div_st_ff == CSCC_DIV_IDLE && DIV_START;
    endsequence
    a_div_length: assert property (@(posedge CLOCK) disable iff (RST)
        s_div_begin ##1 (~HOLD)[*8] |-> ##0 (div_cnt_ff == 5'h0c))
        else $error("divide count wrong");
    a_zero_sticky: assert property (@(posedge CLOCK) disable iff (RST)
        ALU_VALID & ~f_nz |=> status_ff[`CSCC_SR_Z])
        else $error("zero flag not set");

    a_clamp_set_a: assert property (@(posedge CLOCK) disable iff (RST)
        CLAMP_A_EVT |=> status_ff[`CSCC_SR_SA])
        else $error("clamp event lost");
    a_clamp_set_b: assert property (@(posedge CLOCK) disable iff (RST)
        CLAMP_B_EVT |=> status_ff[`CSCC_SR_SB])
        else $error("clamp event lost");
    a_clamp_rise_b: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(status_ff[`CSCC_SR_SB]) |-> $past(CLAMP_B_EVT))
        else $error("clamp flag set without event");
    a_clamp_keep: assert property (@(posedge CLOCK) disable iff (RST)
        status_ff[`CSCC_SR_SA] & ~clr_sa |=> status_ff[`CSCC_SR_SA])
        else $error("clamp flag dropped");

    a_repeat_flag: assert property (@(posedge CLOCK) disable iff (RST)
        ##1 status_ff[`CSCC_SR_RA] == $past(REPEAT_RUN))
        else $error("repeat flag wrong");
    a_guard_spill_b: assert property (@(posedge CLOCK) disable iff (RST)
        ##1 status_ff[`CSCC_SR_OB] == $past(ACC_B[39:32] != 8'h00 && ACC_B[39:32] != 8'hff))
        else $error("guard spill wrong");

    a_prio_join: assert property (@(posedge CLOCK) disable iff (RST)
        CPU_PRIORITY == {control_ff[`CSCC_CC_PRI3], status_ff[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO]})
        else $error("priority not joined");
    a_top_block: assert property (@(posedge CLOCK) disable iff (RST)
        control_ff[`CSCC_CC_PRI3] |-> USER_INT_BLOCK)
        else $error("top priority bit not blocking");
    a_pri_write: assert property (@(posedge CLOCK) disable iff (RST)
        pri_wr |=> status_ff[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO]
            == $past(wd[`CSCC_SR_PRI_HI:`CSCC_SR_PRI_LO]))
        else $error("priority write lost");

    a_ack_pulse: assert property (@(posedge CLOCK) disable iff (RST)
        WB_ACK_O |=> ~WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (@(posedge CLOCK) disable iff (RST)
        bus_req |=> WB_ACK_O)
        else $error("request not acknowledged");
    a_rdata_idle: assert property (@(posedge CLOCK) disable iff (RST)
        ~WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data outside ack");

    a_win_off: assert property (@(posedge CLOCK) disable iff (RST)
        ~control_ff[`CSCC_CC_PSV] |=> ~PROG_WINDOW_HIT)
        else $error("window hit while disabled");
    a_win_low: assert property (@(posedge CLOCK) disable iff (RST)
        control_ff[`CSCC_CC_PSV] & DATA_ADDR[15]
            |=> PROG_WINDOW_HIT && PROG_ADDR[14:0] == $past(DATA_ADDR[14:0]))
        else $error("window address wrong");

    a_minus_one: assert property (@(posedge CLOCK) disable iff (RST)
        MUL_X == 17'h1ffff && MUL_Y == 17'h1ffff |=> MUL_PRODUCT == 34'h1)
        else $error("minus one squared wrong");
    a_shift_cap: assert property (@(posedge CLOCK) disable iff (RST)
        SHIFT_LEFT && SHIFT_AMT >= `CSCC_SHIFT_MAX
            |=> SHIFT_OUT == $past({SHIFT_IN[23:0], 16'h0000}))
        else $error("shift cap wrong");

    sequence s_div_last;
        DIV_BUSY && div_done && !HOLD;
    endsequence
    a_div_hold: assert property (@(posedge CLOCK) disable iff (RST)
        DIV_BUSY & HOLD |=> $stable(div_cnt_ff))
        else $error("divide count moved while held");
    a_div_finish: assert property (@(posedge CLOCK) disable iff (RST)
        s_div_last |=> ~DIV_BUSY && div_cnt_ff == 5'h00)
        else $error("divide did not end");
    a_div_start: assert property (@(posedge CLOCK) disable iff (RST)
        s_div_begin |=> DIV_BUSY && div_cnt_ff == `CSCC_DIV_CYCLES)
        else $error("divide did not start");
endmodule
`default_nettype wire

// ### sim/cscc_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cscc_defs.svh"
module cscc_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  adr = 6'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        alu_v = 1'b0, alu_sub = 1'b0, alu_byte = 1'b0;
    logic [15:0] alu_a = 16'h0, alu_b = 16'h0, daddr = 16'h0;
    logic [39:0] acc_a = 40'h0, acc_b = 40'h0, sh_in = 40'h0;
    logic        clamp_a = 1'b0, clamp_b = 1'b0, blk = 1'b0, rep = 1'b0, nest = 1'b0;
    logic        div_go = 1'b0, hold = 1'b0, sh_left = 1'b0;
    logic [16:0] mx = 17'h0, my = 17'h0;
    logic [4:0]  sh_amt = 5'h0;
    wire  [31:0] dat_o;
    wire         ack, hit, int_block, busy;
    wire  [15:0] alu_r;
    wire  [33:0] prod;
    wire  [39:0] sh_out;
    wire  [22:0] paddr;
    wire  [3:0]  pri;
    int          fail_count = 0, checks = 0, tick_cnt = 0;
    integer      seed = 38069;
    logic [31:0] exp_q[$];
    logic [31:0] rv;

    cscc_core_state uut (.CLOCK(clock), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
        .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .ALU_VALID(alu_v), .ALU_SUB(alu_sub), .ALU_BYTE(alu_byte),
        .ALU_A(alu_a), .ALU_B(alu_b), .ACC_A(acc_a), .ACC_B(acc_b), .CLAMP_A_EVT(clamp_a),
        .CLAMP_B_EVT(clamp_b), .BLOCK_LOOP_RUN(blk), .REPEAT_RUN(rep),
        .NESTING_DISABLE(nest), .DIV_START(div_go), .HOLD(hold), .DATA_ADDR(daddr),
        .MUL_X(mx), .MUL_Y(my), .SHIFT_IN(sh_in), .SHIFT_AMT(sh_amt), .SHIFT_LEFT(sh_left),
        .ALU_RESULT(alu_r), .MUL_PRODUCT(prod), .SHIFT_OUT(sh_out), .PROG_ADDR(paddr),
        .PROG_WINDOW_HIT(hit), .CPU_PRIORITY(pri), .USER_INT_BLOCK(int_block),
        .DIV_BUSY(busy));

    always #10 clock = ~clock;

    task print_verdict;
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk_val(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t port value %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bus(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t read data %h expected %h", $time, got, exp);
        end
    endtask

    // reads are judged at the ack edge, in order of issue
    always @(posedge clock) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("[ERR] %0t read ack with nothing expected", $time);
            end else
                chk_bus(dat_o, exp_q.pop_front());
        end
    end

    // ceiling is far above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        tick_cnt++;
        if (tick_cnt == 20000) begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end

    task wb(input logic [5:0] a, input logic w, input logic [15:0] d);
        @(posedge clock);
        adr <= a; we <= w; dat <= {16'h0, d}; sel <= 4'h3; cyc <= 1'b1; stb <= 1'b1;
        // no answer time assumed; only the bench timeout ends a stuck wait
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task rd(input logic [5:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0, e});
        wb(a, 1'b0, 16'h0);
    endtask

    task alu(input logic [15:0] a, input logic [15:0] b, input logic s, input logic y);
        logic [16:0] r;
        logic [8:0]  l;
        logic [15:0] bb;
        logic        c, dc, n, ov, z;
        bb = s ? ~b : b;
        if (y) begin
            r = a[7:0] + bb[7:0] + s;
            l = a[3:0] + bb[3:0] + s;
            c = r[8]; n = r[7]; z = (r[7:0] == 8'h00); dc = l[4];
            ov = (a[7] == bb[7]) && (r[7] != a[7]);
        end else begin
            r = a + bb + s;
            l = a[7:0] + bb[7:0] + s;
            c = r[16]; n = r[15]; z = (r[15:0] == 16'h0); dc = l[8];
            ov = (a[15] == bb[15]) && (r[15] != a[15]);
        end
        @(posedge clock);
        alu_a <= a; alu_b <= b; alu_sub <= s; alu_byte <= y; alu_v <= 1'b1;
        @(posedge clock);
        alu_v <= 1'b0;
        #1 chk_val(alu_r[7:0], r[7:0]);
        rd(`CSCC_ADR_STATUS, {7'h0, dc, 4'h0, n, ov, z, c});
    endtask

    task mul(input logic [16:0] x, input logic [16:0] y);
        logic [33:0] e;
        e = $signed(x) * $signed(y);
        @(posedge clock);
        mx <= x; my <= y;
        repeat (2) @(posedge clock);
        #1 chk_val(prod, e);
    endtask

    task sh(input logic [39:0] v, input logic [4:0] a, input logic lf, input logic [39:0] e);
        @(posedge clock);
        sh_in <= v; sh_amt <= a; sh_left <= lf;
        repeat (2) @(posedge clock);
        #1 chk_val(sh_out, e);
    endtask

    task div(input logic h, input logic [39:0] e);
        logic [39:0] n;
        n = 0;
        @(posedge clock);
        div_go <= 1'b1;
        @(posedge clock);
        div_go <= 1'b0;
        for (int k = 0; k < 40; k++) begin
            if (k > 0) @(posedge clock);
            hold <= h && k >= 4 && k < 7;
            #1 if (busy === 1'b1) n++;
        end
        chk_val(n, e);
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd(`CSCC_ADR_STATUS, 16'h0000);
        rd(`CSCC_ADR_CONTROL, `CSCC_CC_RST);
        alu(16'h7fff, 16'h0001, 1'b0, 1'b0);
        alu(16'h1234, 16'h1234, 1'b1, 1'b0);
        alu(16'h0008, 16'h0008, 1'b0, 1'b1);
        for (int k = 0; k < 6; k++) begin
            rv = $random(seed);
            alu(rv[15:0], rv[31:16], k[0], k[1]);
        end
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h0000);
        @(posedge clock) clamp_a <= 1'b1;
        @(posedge clock) clamp_a <= 1'b0;
        rd(`CSCC_ADR_STATUS, 16'h2400);
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h3400);
        rd(`CSCC_ADR_STATUS, 16'h2400);
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h3000);
        rd(`CSCC_ADR_STATUS, 16'h0000);
        @(posedge clock) clamp_b <= 1'b1;
        @(posedge clock) clamp_b <= 1'b0;
        rd(`CSCC_ADR_STATUS, 16'h1400);
        @(posedge clock) begin blk <= 1'b1; rep <= 1'b1; end
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h1400);
        rd(`CSCC_ADR_STATUS, 16'h1610);
        @(posedge clock) begin blk <= 1'b0; rep <= 1'b0; acc_a <= 40'h01_0000_0000; end
        rd(`CSCC_ADR_STATUS, 16'h9c00);
        @(posedge clock) begin acc_a <= 40'h0; acc_b <= 40'hff_8000_0000; end
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h0000);
        rd(`CSCC_ADR_STATUS, 16'h0000);
        @(posedge clock) acc_b <= 40'h7f_0000_0000;
        rd(`CSCC_ADR_STATUS, 16'h4800);
        @(posedge clock) acc_b <= 40'h0;
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h00e0);
        rd(`CSCC_ADR_STATUS, 16'h00e0);
        chk_val(pri, 4'h7);
        chk_val(int_block, 1'b1);
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h0060);
        chk_val(int_block, 1'b0);
        @(posedge clock) nest <= 1'b1;
        wb(`CSCC_ADR_STATUS, 1'b1, 16'h00a0);
        rd(`CSCC_ADR_STATUS, 16'h0060);
        @(posedge clock) nest <= 1'b0;
        wb(`CSCC_ADR_CONTROL, 1'b1, 16'hffff);
        rd(`CSCC_ADR_CONTROL, `CSCC_CC_WMASK);
        chk_val(pri, 4'h3);
        wb(`CSCC_ADR_PCWIN, 1'b1, 16'h00a5);
        rd(`CSCC_ADR_PCWIN, 16'h00a5);
        @(posedge clock) daddr <= 16'h9234;
        repeat (2) @(posedge clock);
        #1 chk_val(paddr, 23'h529234);
        chk_val(hit, 1'b1);
        @(posedge clock) daddr <= 16'h1234;
        repeat (2) @(posedge clock);
        #1 chk_val(hit, 1'b0);
        wb(`CSCC_ADR_CONTROL, 1'b1, 16'h0000);
        @(posedge clock) daddr <= 16'h9234;
        repeat (2) @(posedge clock);
        #1 chk_val(hit, 1'b0);
        wb(6'h10, 1'b1, 16'hffff);
        rd(6'h10, 16'h0000);
        mul(17'h1ffff, 17'h1ffff);
        mul(17'h18000, 17'h18000);
        for (int k = 0; k < 3; k++) begin
            rv = $random(seed);
            mul({rv[15], rv[15:0]}, {rv[31], rv[31:16]});
        end
        sh(40'hff_0000_0000, 5'h10, 1'b0, 40'hff_ffff_0000);
        sh(40'h00_0000_1234, 5'h10, 1'b1, 40'h00_1234_0000);
        sh(40'h00_0000_1234, 5'h1f, 1'b1, 40'h00_1234_0000);
        div(1'b0, 40'd19);
        div(1'b1, 40'd22);
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule
`default_nettype wire
